//--- rtl/pps_cfg.svh
// Constants for the power sequencer: offsets, fields, timing
`ifndef PPS_CFG_SVH
`define PPS_CFG_SVH

// Register byte offsets
`define PPS_OFS_ENABLE   12'h000
`define PPS_OFS_SLOTS    12'h004
`define PPS_OFS_DELAYS   12'h008
`define PPS_OFS_CTRL     12'h00C
`define PPS_OFS_STATUS   12'h010

// Control register fields and reset value
`define PPS_CTRL_FACTOR  0
`define PPS_CTRL_SEAL    1
`define PPS_CTRL_LONG    2
`define PPS_CTRL_W       3
`define PPS_CTRL_RST     3'h0

// Rail indices and counts
`define PPS_RAILS        10
`define PPS_SLOTTED_RAILS 8
`define PPS_MAIN_LAST    3
`define PPS_BACKUP_A     4
`define PPS_BACKUP_B     5
`define PPS_LINEAR       6
`define PPS_LV_SWITCH    7
`define PPS_HS_SWITCH_A  8
`define PPS_HS_SWITCH_B  9

// Slot and delay layout
`define PPS_SLOT_W       4
`define PPS_SLOTS        10
`define PPS_DELAYS       9
`define PPS_DCODE_W      2
`define PPS_SLOTS_RST    32'h0000_0000
`define PPS_DELAYS_RST   18'h0_0000

// Timing in printed units
`define PPS_CLK_NS       20
`define PPS_NS_PER_MS    1000000
`define PPS_MS_PER_S     1000
`define PPS_DLY_MIN_MS   2
`define PPS_DLY_MAX_MS   5
`define PPS_PD_FACTOR    10
`define PPS_PD_WINDOW_MS 500
`define PPS_WAIT_EN_S    20
`define PPS_HOLD_S       8
`define PPS_HOLD_LONG_S  15

`endif

//--- rtl/pps_pkg.sv
// Types shared by the power sequencer
package pps_pkg;

    typedef enum logic [2:0] {
        PPS_OFF,
        PPS_PRE_OFF,
        PPS_WAIT_EN,
        PPS_ACTIVE,
        PPS_SUSPEND,
        PPS_RECOVERY
    } pps_state_t;

    typedef logic [3:0] pps_slot_t;

endpackage

//--- rtl/pps_power_sequencer.sv
// Power-up/power-down sequencer with APB register access
// Operation
// - Ten slots, nine delays per sequence
// - Each of rails 0..7 in one slot; slots shared
// - Each delay lasts two to five ms
// - Power-up fires slots one through ten
// - Wake on edges or host enable
// - Wake event enters wait-for-enable state
// - Twenty seconds without enable powers down
// - Host enable moves to active state
// - Slot zero rails left untouched by power-up
// - Enable register refused while sequencing
// - Enable bits track actual rail state
// - Power-down runs slots ten to one
// - Factor bit stretches power-down delays tenfold
// - Final state exactly 500 ms later
// - Host enable low in active powers down
// - Long button hold powers down
// - Internal faults start power-down
// - Suspend keeps unsequenced rails unchanged
// - Unsequenced rails except backups off early, switches late
// - Slots one, two only backup rails
// - Backup slots fire every power-up
// - Seal bit skips slots two, one
// - Power good low on power-down
`timescale 1ns/1ps
`include "pps_cfg.svh"

module pps_power_sequencer
    import pps_pkg::*;
#(
    parameter int TICK_CYCLES = (`PPS_NS_PER_MS / `PPS_CLK_NS)
)(
    input  wire logic                   ref_clk,
    input  wire logic                   rst,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [11:0]            paddr,
    input  wire logic [31:0]            pwdata,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    input  wire logic                   wakeButtonN,
    input  wire logic                   adapterDetectN,
    input  wire logic                   hostPowerEnable,
    input  wire logic                   undervoltageLockout,
    input  wire logic                   thermalShutdown,
    input  wire logic                   powerGoodFail,
    output logic      [`PPS_RAILS-1:0]  railEnable,
    output logic      [`PPS_RAILS-1:0]  railDischarge,
    output logic                        powerGoodOut
);

    // Elaboration check on the millisecond divider
    if (TICK_CYCLES < 1 || TICK_CYCLES > 65536) begin : g_bad_tick
        $error("TICK_CYCLES out of range");
    end

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    // Slot of one rail; the high-side switches are never sequenced
    function automatic pps_slot_t slotOf(input logic [31:0] cfg, input int r);
        slotOf = (r < `PPS_SLOTTED_RAILS) ? cfg[r*`PPS_SLOT_W +: `PPS_SLOT_W] : 4'h0;
    endfunction

    // Delay n (1..9) in ms, 2..5 from a two-bit code
    function automatic logic [5:0] dlyMs(input logic [17:0] cfg, input pps_slot_t n);
        logic [1:0] code;
        code  = cfg[(int'(n) - 1)*`PPS_DCODE_W +: `PPS_DCODE_W];
        dlyMs = 6'(`PPS_DLY_MIN_MS) + {4'h0, code};
    endfunction

    // Legal slot values only; others store as unassigned
    function automatic logic [31:0] cleanSlots(input logic [31:0] w);
        logic      [31:0] res;
        pps_slot_t        v;
        logic             bk;
        res = 32'h0;
        for (int r = 0; r < `PPS_SLOTTED_RAILS; r++) begin
            v  = w[r*`PPS_SLOT_W +: `PPS_SLOT_W];
            bk = (r == `PPS_BACKUP_A) || (r == `PPS_BACKUP_B);
            if (bk && v > 4'h2)
                v = 4'h0;
            if (!bk && (v == 4'h1 || v == 4'h2 || v > 4'hA))
                v = 4'h0;
            res[r*`PPS_SLOT_W +: `PPS_SLOT_W] = v;
        end
        cleanSlots = res;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // State

    pps_state_t        state;
    pps_state_t        next_state;
    pps_state_t        target;
    pps_state_t        next_target;
    logic              upRun;
    logic              next_upRun;
    logic              downRun;
    logic              next_downRun;
    logic              firePend;
    logic              next_firePend;
    pps_slot_t         slotIdx;
    pps_slot_t         next_slotIdx;
    logic [5:0]        dlyCnt;
    logic [5:0]        next_dlyCnt;
    logic [8:0]        winCnt;
    logic [8:0]        next_winCnt;
    logic [14:0]       waitCnt;
    logic [13:0]       holdCnt;
    logic [15:0]       tickCnt;
    logic              btnPrev;
    logic              adPrev;
    logic [`PPS_RAILS-1:0] next_rail;
    logic [`PPS_RAILS-1:0] next_disch;
    logic [31:0]       slotCfg;
    logic [17:0]       dlyCfg;
    logic [`PPS_CTRL_W-1:0] ctrl;

    ////////////////////////////////////////////////////////////////////////
    // Millisecond tick and timers

    wire busy        = upRun | downRun;
    wire fault       = undervoltageLockout | thermalShutdown | powerGoodFail;
    wire tick        = (tickCnt == 16'(TICK_CYCLES - 1));
    wire btnFall     = btnPrev & ~wakeButtonN;
    wire adFall      = adPrev & ~adapterDetectN;
    wire factorOn    = ctrl[`PPS_CTRL_FACTOR];
    wire sealOn      = ctrl[`PPS_CTRL_SEAL];
    wire longHold    = ctrl[`PPS_CTRL_LONG];
    wire inWait      = (state == PPS_WAIT_EN);
    wire inActive    = (state == PPS_ACTIVE);
    wire inSuspend   = (state == PPS_SUSPEND);
    wire live        = inWait | inActive | inSuspend;
    wire asleep      = (state == PPS_OFF) | (state == PPS_PRE_OFF) | inSuspend;

    // Hold limits in ms
    wire [13:0] holdLimit = longHold ? 14'(`PPS_HOLD_LONG_S * `PPS_MS_PER_S)
                                     : 14'(`PPS_HOLD_S * `PPS_MS_PER_S);
    wire [14:0] waitLimit = 15'(`PPS_WAIT_EN_S * `PPS_MS_PER_S);

    // Power-down causes, fault first
    wire holdTrip    = live & (holdCnt > holdLimit);
    wire waitTrip    = inWait & wakeButtonN & adapterDetectN
                     & ~hostPowerEnable & (waitCnt >= waitLimit);
    wire hostDrop    = inActive & ~hostPowerEnable;
    wire downReq     = ~downRun & live & (fault | holdTrip | waitTrip | hostDrop);
    wire pps_state_t downTgt = fault ? PPS_RECOVERY
                             : ((hostDrop & ~holdTrip) ? PPS_SUSPEND : PPS_OFF);

    // Wake: edges, or host enable as a level; blocked by lockout
    wire wakeEvt     = ~downRun & ~downReq & asleep
                     & (btnFall | adFall | hostPowerEnable)
                     & ~undervoltageLockout & ~thermalShutdown;

    // Restart the divider so sequence timing is exact from its start
    wire tickRestart = downReq | wakeEvt;

    // Divider giving one tick per millisecond
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst)
            tickCnt <= 16'h0;
        else if (tickRestart || tick)
            tickCnt <= 16'h0;
        else
            tickCnt <= tickCnt + 16'h1;
    end

    // Wait-for-enable window and button hold, saturating
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            waitCnt <= 15'h0;
            holdCnt <= 14'h0;
        end else begin
            if (!inWait)
                waitCnt <= 15'h0;
            else if (tick && waitCnt < waitLimit)
                waitCnt <= waitCnt + 15'h1;
            if (wakeButtonN || !live)
                holdCnt <= 14'h0;
            else if (tick && holdCnt != 14'h3FFF)
                holdCnt <= holdCnt + 14'h1;
        end
    end

    // Edge detectors, idle high
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            btnPrev <= 1'b1;
            adPrev  <= 1'b1;
        end else begin
            btnPrev <= wakeButtonN;
            adPrev  <= adapterDetectN;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // APB slave

    wire        setup    = psel & ~penable;
    wire        access   = psel & penable;
    wire        hitEn    = (paddr == `PPS_OFS_ENABLE);
    wire        hitSlots = (paddr == `PPS_OFS_SLOTS);
    wire        hitDly   = (paddr == `PPS_OFS_DELAYS);
    wire        hitCtrl  = (paddr == `PPS_OFS_CTRL);
    wire        hitStat  = (paddr == `PPS_OFS_STATUS);
    wire        mapped   = hitEn | hitSlots | hitDly | hitCtrl | hitStat;
    wire        enLocked = hitEn & busy;
    wire        wrOk     = access & pwrite & ~enLocked;
    wire        enWrite  = wrOk & hitEn;
    wire [31:0] statusWord = {26'h0, downRun, upRun, powerGoodOut, state};
    wire [31:0] readMux  =
        (hitEn & ~busy) ? {22'h0, railEnable} :
        hitSlots        ? slotCfg :
        hitDly          ? {14'h0, dlyCfg} :
        hitCtrl         ? {29'h0, ctrl} :
        hitStat         ? statusWord : 32'h0;

    // Always ready; error on unmapped or locked enable access
    assign pready  = 1'b1;
    assign pslverr = access & (~mapped | enLocked);

    // Read data captured in the setup phase
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst)
            prdata <= 32'h0;
        else if (setup && !pwrite)
            prdata <= readMux;
    end

    // Configuration registers
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            slotCfg <= `PPS_SLOTS_RST;
            dlyCfg  <= `PPS_DELAYS_RST;
            ctrl    <= `PPS_CTRL_RST;
        end else begin
            if (wrOk && hitSlots)
                slotCfg <= cleanSlots(pwdata);
            if (wrOk && hitDly)
                dlyCfg  <= pwdata[17:0];
            if (wrOk && hitCtrl)
                ctrl    <= pwdata[`PPS_CTRL_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer next-state logic

    // Whether the current slot is the last one of this pass
    wire lastSlot = upRun ? (slotIdx == 4'(`PPS_SLOTS))
                          : ((slotIdx == 4'h1) || (sealOn && slotIdx == 4'h3));
    // Delay ahead of the next slot; reverse pass uses the lower index
    wire [5:0] upDly   = dlyMs(dlyCfg, slotIdx);
    wire [5:0] baseDn  = dlyMs(dlyCfg, 4'(slotIdx - 4'h1));
    wire [5:0] downDly = factorOn ? 6'(baseDn * 6'(`PPS_PD_FACTOR)) : baseDn;
    wire       winEnd  = downRun & tick & (winCnt == 9'(`PPS_PD_WINDOW_MS - 1));

    always_comb begin
        next_state    = state;
        next_target   = target;
        next_upRun    = upRun;
        next_downRun  = downRun;
        next_firePend = firePend;
        next_slotIdx  = slotIdx;
        next_dlyCnt   = dlyCnt;
        next_winCnt   = winCnt;
        next_rail     = railEnable;
        next_disch    = railDischarge;
        // Software enable, only while idle
        if (enWrite) begin
            next_rail  = pwdata[`PPS_RAILS-1:0];
            next_disch = railDischarge & ~pwdata[`PPS_RAILS-1:0];
        end
        if (downReq) begin
            // Start reverse pass from the top slot
            next_downRun  = 1'b1;
            next_upRun    = 1'b0;
            next_slotIdx  = 4'(`PPS_SLOTS);
            next_firePend = 1'b1;
            next_dlyCnt   = 6'h0;
            next_winCnt   = 9'h0;
            next_target   = downTgt;
            if (downTgt != PPS_SUSPEND) begin
                for (int r = 0; r < `PPS_SLOTTED_RAILS; r++) begin
                    if (slotOf(slotCfg, r) == 4'h0
                        && r != `PPS_BACKUP_A && r != `PPS_BACKUP_B) begin
                        next_rail[r]  = 1'b0;
                        next_disch[r] = 1'b1;
                    end
                end
            end
        end else if (wakeEvt) begin
            next_state    = PPS_WAIT_EN;
            next_upRun    = 1'b1;
            next_slotIdx  = 4'h1;
            next_firePend = 1'b1;
            next_dlyCnt   = 6'h0;
        end else begin
            if (inWait && hostPowerEnable)
                next_state = PPS_ACTIVE;
            if (state == PPS_RECOVERY && !fault)
                next_state = PPS_PRE_OFF;
            if (busy && firePend) begin
                // Fire slot; unassigned rails never match
                if (!(downRun && sealOn && slotIdx <= 4'h2)) begin
                    for (int r = 0; r < `PPS_SLOTTED_RAILS; r++) begin
                        if (slotOf(slotCfg, r) == slotIdx) begin
                            next_rail[r]  = upRun;
                            next_disch[r] = downRun;
                        end
                    end
                end
                next_firePend = 1'b0;
                if (lastSlot) begin
                    next_upRun  = 1'b0;
                    next_dlyCnt = 6'h0;
                end else if (upRun) begin
                    next_dlyCnt  = upDly;
                    next_slotIdx = slotIdx + 4'h1;
                end else begin
                    next_dlyCnt  = downDly;
                    next_slotIdx = slotIdx - 4'h1;
                end
            end else if (busy && tick && dlyCnt != 6'h0) begin
                next_dlyCnt = dlyCnt - 6'h1;
                if (dlyCnt == 6'h1)
                    next_firePend = 1'b1;
            end
            if (downRun && tick)
                next_winCnt = winCnt + 9'h1;
            if (winEnd) begin
                // Window end: final state whatever the delays were
                next_downRun  = 1'b0;
                next_firePend = 1'b0;
                next_dlyCnt   = 6'h0;
                next_state    = target;
                if (target != PPS_SUSPEND) begin
                    next_rail[`PPS_HS_SWITCH_A]  = 1'b0;
                    next_rail[`PPS_HS_SWITCH_B]  = 1'b0;
                    next_disch[`PPS_HS_SWITCH_A] = 1'b1;
                    next_disch[`PPS_HS_SWITCH_B] = 1'b1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer registers

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state    <= PPS_OFF;
            target   <= PPS_OFF;
            upRun    <= 1'b0;
            downRun  <= 1'b0;
            firePend <= 1'b0;
            slotIdx  <= 4'h1;
            dlyCnt   <= 6'h0;
            winCnt   <= 9'h0;
        end else begin
            state    <= next_state;
            target   <= next_target;
            upRun    <= next_upRun;
            downRun  <= next_downRun;
            firePend <= next_firePend;
            slotIdx  <= next_slotIdx;
            dlyCnt   <= next_dlyCnt;
            winCnt   <= next_winCnt;
        end
    end

    // Rail outputs are the enable register itself
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            railEnable    <= '0;
            railDischarge <= '0;
        end else begin
            railEnable    <= next_rail;
            railDischarge <= next_disch;
        end
    end

    // Power good only when settled in active; drops at once on power-down
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst)
            powerGoodOut <= 1'b0;
        else
            powerGoodOut <= (next_state == PPS_ACTIVE) & ~next_upRun
                          & ~next_downRun & ~powerGoodFail;
    end

endmodule

//--- verif/pps_power_sequencer_checker.sv
// Port-level assertions for the power sequencer
`timescale 1ns/1ps
`include "pps_cfg.svh"
module pps_power_sequencer_checker
    import pps_pkg::*;
(
    input wire logic                  ref_clk,
    input wire logic                  rst,
    input wire logic                  psel,
    input wire logic                  penable,
    input wire logic                  pwrite,
    input wire logic [11:0]           paddr,
    input wire logic                  pready,
    input wire logic                  pslverr,
    input wire logic                  wakeButtonN,
    input wire logic                  hostPowerEnable,
    input wire logic                  undervoltageLockout,
    input wire logic                  thermalShutdown,
    input wire logic                  powerGoodFail,
    input wire logic [`PPS_RAILS-1:0] railEnable,
    input wire logic [`PPS_RAILS-1:0] railDischarge,
    input wire logic                  powerGoodOut
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    ////////////////////////////////////////////////////////////////////////////
    // Start of a power-down and the calm active state, as seen at the pins
    sequence s_down;
        $fell(powerGoodOut) && railEnable[`PPS_HS_SWITCH_A];
    endsequence
    sequence s_calm;
        powerGoodOut && $past(powerGoodOut) && $past(hostPowerEnable) && $past(wakeButtonN)
            && !$past(undervoltageLockout || thermalShutdown || powerGoodFail);
    endsequence

    // Zero wait states promised to the bus
    pready_high_a: assert property (pready) else $error("pready low");
    slverr_access_a: assert property (pslverr |-> psel && penable)
        else $error("pslverr outside access");
    unmapped_err_a: assert property (psel && penable && paddr > 12'h010 |-> pslverr)
        else $error("unmapped access not refused");
    good_fault_a: assert property ($rose(thermalShutdown || undervoltageLockout)
        |-> ##[1:3] !powerGoodOut) else $error("power good kept on fault");
    good_host_a: assert property (powerGoodOut
        |-> $past(hostPowerEnable) || $past(hostPowerEnable, 2)) else $error("good without host");
    // Switches are shed only when the window closes, never at the trigger
    hs_hold_a: assert property (s_down |-> railEnable[`PPS_HS_SWITCH_A] [*8])
        else $error("switch dropped early");
    rail_discharge_a: assert property ($fell(railEnable[0]) && !$past(pwrite)
        |-> railDischarge[0]) else $error("no discharge on rail off");
    quiet_rails_a: assert property (s_calm and $changed(railEnable)
        |-> $past(psel && penable && pwrite && paddr == 12'h000)) else $error("rail moved");
endmodule

bind pps_power_sequencer pps_power_sequencer_checker u_chk (.ref_clk(ref_clk), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready),
    .pslverr(pslverr), .wakeButtonN(wakeButtonN), .hostPowerEnable(hostPowerEnable),
    .undervoltageLockout(undervoltageLockout), .thermalShutdown(thermalShutdown),
    .powerGoodFail(powerGoodFail), .railEnable(railEnable), .railDischarge(railDischarge),
    .powerGoodOut(powerGoodOut));

//--- verif/pps_host_model.sv
// Host processor model that drives the power-enable pin
`timescale 1ns/1ps
module pps_host_model #(
    parameter int LAG = 3
)(
    input  wire logic ref_clk,
    input  wire logic rst,
    input  wire logic wantOn,
    output logic      hostPowerEnable
);
    logic [7:0] cnt;

    // Pin follows the request after a fixed lag, as firmware would
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cnt             <= 8'h00;
            hostPowerEnable <= 1'b0;
        end else if (wantOn == hostPowerEnable) begin
            cnt <= 8'h00;
        end else if (cnt == LAG[7:0]) begin
            hostPowerEnable <= wantOn;
            cnt             <= 8'h00;
        end else begin
            cnt <= cnt + 8'h01;
        end
    end
endmodule

//--- verif/pps_power_sequencer_tb_top.sv
// Self-checking bench for the power sequencer
`timescale 1ns/1ps
`include "pps_cfg.svh"
module pps_power_sequencer_tb_top;
    // Short tick keeps the 500 ms window near a thousand cycles
    localparam int TK = 2;
    logic                  ref_clk, rst, psel, penable, pwrite, pready, pslverr, er;
    logic                  wakeButtonN, hostPowerEnable, thermalShutdown, wantOn, powerGoodOut;
    logic                  adapterDetectN, undervoltageLockout;
    logic [11:0]           paddr;
    logic [31:0]           pwdata, prdata, rd;
    logic [`PPS_RAILS-1:0] railEnable, railDischarge;
    int                    failures = 0, compares = 0, cyc = 0, n, t0;

    pps_power_sequencer #(.TICK_CYCLES(TK)) dut (.ref_clk(ref_clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .wakeButtonN(wakeButtonN),
        .adapterDetectN(adapterDetectN), .hostPowerEnable(hostPowerEnable),
        .undervoltageLockout(undervoltageLockout), .thermalShutdown(thermalShutdown),
        .powerGoodFail(1'b0), .railEnable(railEnable),
        .railDischarge(railDischarge), .powerGoodOut(powerGoodOut));
    pps_host_model host (.ref_clk(ref_clk), .rst(rst), .wantOn(wantOn),
        .hostPowerEnable(hostPowerEnable));

    ////////////////////////////////////////////////////////////////////////////
    // Clock and hang guard
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            failures++;
            results();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Shared helpers
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Index 10 waits on power good; registered outputs, so edge sampling is safe
    task waitr(input int b, input logic v);
        n = 0;
        while (((b == 10) ? powerGoodOut : railEnable[b]) !== v && n < 3000) begin
            @(posedge ref_clk);
            n++;
        end
        chk("wait limit", 32'h0, n >= 3000);
    endtask
    task results;
        $display("Comparisons %0d, mismatches %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task t_regs;
        apb(1'b0, `PPS_OFS_STATUS, 32'h0);
        chk("status reset", 32'h0000_0000, rd);
        apb(1'b0, 12'h020, 32'h0);
        chk("unmapped error", 32'h1, er);
        apb(1'b1, `PPS_OFS_SLOTS, 32'h0021_00A1);
        apb(1'b0, `PPS_OFS_SLOTS, 32'h0);
        chk("slot one refused", 32'h0021_00A0, rd);
        apb(1'b1, `PPS_OFS_SLOTS, 32'h0021_00A3);
        apb(1'b1, `PPS_OFS_DELAYS, 32'h0000_000C);
        apb(1'b1, `PPS_OFS_ENABLE, 32'h0000_0104);
        apb(1'b0, `PPS_OFS_ENABLE, 32'h0);
        chk("manual rails", 32'h0000_0104, rd);
        $display("regs test done");
    endtask
    task t_up;
        @(posedge ref_clk);
        wakeButtonN <= 1'b0;
        @(posedge ref_clk);
        wakeButtonN <= 1'b1;
        waitr(4, 1'b1);
        chk("slot one lag", 32'h1, n >= 1 && n <= 4);
        waitr(5, 1'b1);
        chk("delay one", 2 * TK, n);
        waitr(0, 1'b1);
        chk("delay two", 5 * TK, n);
        apb(1'b0, `PPS_OFS_ENABLE, 32'h0);
        chk("enable locked", 32'h1, er);
        chk("locked data", 32'h0, rd);
        waitr(1, 1'b1);
        chk("unsequenced kept", 32'h1, railEnable[2]);
        wantOn <= 1'b1;
        waitr(10, 1'b1);
        apb(1'b0, `PPS_OFS_STATUS, 32'h0);
        chk("active status", 32'h0000_000B, rd);
        apb(1'b1, `PPS_OFS_ENABLE, 32'h0000_0337);
        apb(1'b0, `PPS_OFS_ENABLE, 32'h0);
        chk("rails active", 32'h0000_0337, rd);
        $display("power-up test done");
    endtask
    task t_suspend;
        wantOn <= 1'b0;
        waitr(10, 1'b0);
        t0 = cyc;
        waitr(1, 1'b0);
        chk("discharge on", 32'h1, railDischarge[1]);
        waitr(0, 1'b0);
        chk("down gap", 14 * TK, n);
        waitr(5, 1'b0);
        chk("slot two down", 5 * TK, n);
        waitr(4, 1'b0);
        chk("slot one down", 2 * TK, n);
        chk("kept rails", 32'h0000_0304, railEnable);
        while (cyc < t0 + 500 * TK - 8) @(posedge ref_clk);
        apb(1'b0, `PPS_OFS_STATUS, 32'h0);
        chk("window open", 32'h1, rd[5] && rd[2:0] != 3'h4);
        while (cyc < t0 + 500 * TK + 8) @(posedge ref_clk);
        apb(1'b0, `PPS_OFS_STATUS, 32'h0);
        chk("suspend status", 32'h0000_0004, rd);
        $display("suspend test done");
    endtask
    task t_recover;
        apb(1'b1, `PPS_OFS_CTRL, 32'h0000_0003);
        wantOn <= 1'b1;
        waitr(10, 1'b1);
        chk("backup refired", 32'h1, railEnable[5]);
        thermalShutdown <= 1'b1;
        waitr(10, 1'b0);
        t0 = cyc;
        waitr(2, 1'b0);
        chk("early off", 32'h1, n <= 3);
        chk("switch still on", 32'h1, railEnable[8]);
        waitr(1, 1'b0);
        waitr(0, 1'b0);
        chk("stretched gap", 140 * TK, n);
        while (cyc < t0 + 500 * TK + 8) @(posedge ref_clk);
        chk("switches off", 32'h0, railEnable[9:8]);
        chk("sealed backups", 32'h3, railEnable[5:4]);
        apb(1'b0, `PPS_OFS_STATUS, 32'h0);
        chk("recovery status", 32'h0000_0005, rd);
        wantOn <= 1'b0;
        repeat (10) @(posedge ref_clk);
        thermalShutdown <= 1'b0;
        repeat (5) @(posedge ref_clk);
        apb(1'b0, `PPS_OFS_STATUS, 32'h0);
        chk("pre-off status", 32'h0000_0001, rd);
        $display("recovery test done");
    endtask
    // Lockout must swallow an adapter edge; a clean edge then wakes from pre-off
    task t_wake;
        undervoltageLockout <= 1'b1;
        adapterDetectN <= 1'b0;
        repeat (4) @(posedge ref_clk);
        apb(1'b0, `PPS_OFS_STATUS, 32'h0);
        chk("lockout blocks wake", 32'h0000_0001, rd);
        undervoltageLockout <= 1'b0;
        adapterDetectN <= 1'b1;
        @(posedge ref_clk);
        adapterDetectN <= 1'b0;
        repeat (2) @(posedge ref_clk);
        apb(1'b0, `PPS_OFS_STATUS, 32'h0);
        chk("adapter wake", 32'h0000_0012, rd);
        $display("wake test done");
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        wakeButtonN = 1'b1;
        adapterDetectN = 1'b1;
        undervoltageLockout = 1'b0;
        thermalShutdown = 1'b0;
        wantOn = 1'b0;
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        t_regs();
        t_up();
        t_suspend();
        t_recover();
        t_wake();
        results();
    end
endmodule
